// ==== rtl/ebs_pkg.sv ====
package ebs_pkg;
    // Control clock and the 0.01 s step that every wait timer counts in.
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FREQ_W = 16;
    localparam int unsigned CUR_W = 8;
    localparam int unsigned WAIT_W = 10;
    localparam int unsigned RCUR_W = 5;
    localparam int unsigned EV_W = 4;
    localparam int unsigned ST_W = 11;

    // Byte addresses of the register words.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_REL_WAIT = 8'h04;
    localparam logic [7:0] A_ACC_WAIT = 8'h08;
    localparam logic [7:0] A_STOP_WAIT = 8'h0c;
    localparam logic [7:0] A_CONF_WAIT = 8'h10;
    localparam logic [7:0] A_REL_FREQ = 8'h14;
    localparam logic [7:0] A_REL_CUR = 8'h18;
    localparam logic [7:0] A_STATUS = 8'h1c;
    localparam logic [7:0] A_INT_STAT = 8'h20;
    localparam logic [7:0] A_INT_CLR = 8'h24;
    localparam logic [7:0] A_INT_EN = 8'h28;

    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_BOK_BIT = 1;
    localparam int unsigned CTRL_TRST_BIT = 2;
    localparam int unsigned STAT_BOK_BIT = 11;
    localparam int unsigned STAT_ERR_BIT = 12;

    // Setting limits in register units: 0.01 s, 0.01 Hz, 0.1 x rated current.
    localparam logic [WAIT_W-1:0] WAIT_MAX = 10'h1f4;
    localparam logic [FREQ_W-1:0] RFREQ_MAX = 16'h9c40;
    localparam logic [RCUR_W-1:0] RCUR_MAX = 5'h14;
    localparam logic [RCUR_W-1:0] RCUR_RST = 5'h0a;

    localparam int unsigned EV_REL_CUR = 0;
    localparam int unsigned EV_CONF_ON = 1;
    localparam int unsigned EV_CONF_OFF = 2;
    localparam int unsigned EV_CONF_LOST = 3;

    typedef enum logic [ST_W-1:0] {
        S_IDLE = 11'h001,
        S_UP = 11'h002,
        S_REL_WAIT = 11'h004,
        S_CONF_ON = 11'h008,
        S_ACC_WAIT = 11'h010,
        S_RUN = 11'h020,
        S_DOWN = 11'h040,
        S_CONF_OFF = 11'h080,
        S_STOP_WAIT = 11'h100,
        S_ZERO = 11'h200,
        S_TRIP = 11'h400
    } ebs_state_e;
endpackage

// ==== rtl/ebs_wait_timer.sv ====
`timescale 1ns/100ps
module ebs_wait_timer #(
    parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYC,
    parameter int unsigned CNT_W = ebs_pkg::WAIT_W
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic start_in,
    input wire logic [CNT_W-1:0] limit_in,
    output logic done_out
);
    localparam int unsigned PRE_W = $clog2(TICK_CYCLES + 1);

    logic [PRE_W-1:0] pre_q;
    logic [CNT_W-1:0] cnt_q;
    logic tick;

    // The prescaler restarts with the count so a wait is never cut short.
    assign tick = (pre_q == PRE_W'(TICK_CYCLES - 1));
    assign done_out = (cnt_q >= limit_in);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pre_q <= '0;
            cnt_q <= '0;
        end else if (ce_in) begin
            if (start_in) begin
                pre_q <= '0;
                cnt_q <= '0;
            end else if (!done_out) begin
                pre_q <= tick ? '0 : pre_q + 1'b1;
                cnt_q <= tick ? cnt_q + 1'b1 : cnt_q;
            end
        end
    end
endmodule

// ==== rtl/ebs_ahb_slave.sv ====
`timescale 1ns/100ps
module ebs_ahb_slave #(
    parameter int unsigned AW = ebs_pkg::ADDR_W
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic hsel_in,
    input wire logic [AW-1:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] rdata_in,
    output logic wr_en_out,
    output logic [AW-1:0] addr_out,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);
    logic wr_pend_q;
    logic rd_pend_q;
    logic accept;

    // Reads take one wait state so that read data leave a flip-flop and a
    // write in the previous data phase is already visible.
    assign accept = hsel_in & htrans_in[1] & hready_in;
    assign wr_en_out = wr_pend_q;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_out <= '0;
            hrdata_out <= '0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else if (ce_in) begin
            wr_pend_q <= accept & hwrite_in;
            rd_pend_q <= accept & ~hwrite_in;
            hreadyout_out <= ~(accept & ~hwrite_in);
            if (accept) begin
                addr_out <= haddr_in;
            end
            if (rd_pend_q) begin
                hrdata_out <= rdata_in;
            end
        end
    end
endmodule

// ==== rtl/ebs_sequencer.sv ====
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Contract
// - Sequencing runs only while enable is set.
// - On run, ramp to release frequency, hold.
// - Then wait release-confirm time, assert release.
// - Current below threshold at expiry: error, trip.
// - Assigned confirm: await on, else error.
// - No confirm input: skip confirmation waits.
// - Wait acceleration time, then commanded frequency.
// - Run off: ramp to release, drop release.
// - Assigned confirm: await off, else error.
// - Wait stop time, then decelerate to zero.
// - Confirm lost while released in decel: error.
// - Release frequency 0.00 to 400.0 Hz.
// - Confirm and stop waits 0.00-5.00 s.
module ebs_sequencer #(
    parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYC,
    parameter int unsigned FREQ_W = ebs_pkg::FREQ_W,
    parameter int unsigned CUR_W = ebs_pkg::CUR_W
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic run_cmd_in,
    input wire logic [FREQ_W-1:0] cmd_freq_in,
    input wire logic [FREQ_W-1:0] out_freq_in,
    input wire logic [CUR_W-1:0] out_current_in,
    input wire logic brake_confirm_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic brake_release_out,
    output logic brake_error_out,
    output logic trip_out,
    output logic motor_run_out,
    output logic [FREQ_W-1:0] freq_target_out,
    output logic irq_out
);
    localparam int unsigned AW = ebs_pkg::ADDR_W;
    localparam int unsigned WW = ebs_pkg::WAIT_W;
    localparam int unsigned RW = ebs_pkg::RCUR_W;
    localparam int unsigned EW = ebs_pkg::EV_W;

    if (TICK_CYCLES < 1 || FREQ_W < ebs_pkg::FREQ_W || CUR_W < RW) begin : g_bad_param
        $error("ebs_sequencer: unsupported parameter value");
    end

    function automatic logic [FREQ_W-1:0] sat(input logic [31:0] v, input logic [31:0] mx);
        sat = (v > mx) ? FREQ_W'(mx) : FREQ_W'(v);
    endfunction

    ebs_pkg::ebs_state_e state_q;
    ebs_pkg::ebs_state_e state_d;
    logic ctrl_en_q;
    logic bok_assigned_q;
    logic [WW-1:0] rel_wait_q;
    logic [WW-1:0] acc_wait_q;
    logic [WW-1:0] stop_wait_q;
    logic [WW-1:0] conf_wait_q;
    logic [FREQ_W-1:0] rel_freq_q;
    logic [RW-1:0] rel_cur_q;
    logic [EW-1:0] int_stat_q;
    logic [EW-1:0] int_stat_d;
    logic [EW-1:0] int_en_q;
    logic [EW-1:0] ev;
    logic run_prev_q;
    logic run_rise;
    logic bypass;
    logic released_d;
    logic [FREQ_W-1:0] freq_d;
    logic [WW-1:0] wait_limit;
    logic wait_done;
    logic wait_start;
    logic bus_wr;
    logic [AW-1:0] bus_addr;
    logic [31:0] rdata;
    logic wr_ctrl;
    logic wr_int_clr;
    logic trip_clear;
    logic cur_low;
    logic at_rel_up;
    logic at_rel_down;

    ebs_ahb_slave #(
        .AW(AW)
    ) u_bus (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in[AW-1:0]),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hready_in(hready_in),
        .rdata_in(rdata),
        .wr_en_out(bus_wr),
        .addr_out(bus_addr),
        .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out)
    );

    // One timer serves every wait because only one wait state is live at a time.
    ebs_wait_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .CNT_W(WW)
    ) u_timer (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .start_in(wait_start),
        .limit_in(wait_limit),
        .done_out(wait_done)
    );

    assign wait_start = (state_d != state_q);
    assign wait_limit = (state_q == ebs_pkg::S_REL_WAIT) ? rel_wait_q :
                        (state_q == ebs_pkg::S_ACC_WAIT) ? acc_wait_q :
                        (state_q == ebs_pkg::S_STOP_WAIT) ? stop_wait_q : conf_wait_q;

    assign wr_ctrl = bus_wr && (bus_addr == ebs_pkg::A_CTRL);
    assign wr_int_clr = bus_wr && (bus_addr == ebs_pkg::A_INT_CLR);
    assign trip_clear = wr_ctrl && hwdata_in[ebs_pkg::CTRL_TRST_BIT];
    assign run_rise = run_cmd_in && !run_prev_q;
    assign cur_low = (out_current_in < CUR_W'(rel_cur_q));
    assign at_rel_up = (out_freq_in >= rel_freq_q);
    assign at_rel_down = (out_freq_in <= rel_freq_q);
    assign bypass = !ctrl_en_q && (state_q == ebs_pkg::S_IDLE);

    always_comb begin
        state_d = state_q;
        ev = '0;
        case (state_q)
            ebs_pkg::S_IDLE: begin
                if (ctrl_en_q && run_rise) begin
                    state_d = ebs_pkg::S_UP;
                end
            end
            ebs_pkg::S_UP: begin
                if (!run_cmd_in) begin
                    state_d = ebs_pkg::S_ZERO;
                end else if (at_rel_up) begin
                    state_d = ebs_pkg::S_REL_WAIT;
                end
            end
            ebs_pkg::S_REL_WAIT: begin
                if (wait_done && cur_low) begin
                    state_d = ebs_pkg::S_TRIP;
                    ev[ebs_pkg::EV_REL_CUR] = 1'b1;
                end else if (wait_done) begin
                    state_d = bok_assigned_q ? ebs_pkg::S_CONF_ON : ebs_pkg::S_ACC_WAIT;
                end
            end
            ebs_pkg::S_CONF_ON: begin
                if (brake_confirm_in) begin
                    state_d = ebs_pkg::S_ACC_WAIT;
                end else if (wait_done) begin
                    state_d = ebs_pkg::S_TRIP;
                    ev[ebs_pkg::EV_CONF_ON] = 1'b1;
                end
            end
            ebs_pkg::S_ACC_WAIT: begin
                if (wait_done) begin
                    state_d = ebs_pkg::S_RUN;
                end
            end
            ebs_pkg::S_RUN: begin
                if (!run_cmd_in) begin
                    state_d = ebs_pkg::S_DOWN;
                end
            end
            ebs_pkg::S_DOWN: begin
                if (bok_assigned_q && !brake_confirm_in) begin
                    state_d = ebs_pkg::S_TRIP;
                    ev[ebs_pkg::EV_CONF_LOST] = 1'b1;
                end else if (at_rel_down) begin
                    state_d = bok_assigned_q ? ebs_pkg::S_CONF_OFF : ebs_pkg::S_STOP_WAIT;
                end
            end
            ebs_pkg::S_CONF_OFF: begin
                if (!brake_confirm_in) begin
                    state_d = ebs_pkg::S_STOP_WAIT;
                end else if (wait_done) begin
                    state_d = ebs_pkg::S_TRIP;
                    ev[ebs_pkg::EV_CONF_OFF] = 1'b1;
                end
            end
            ebs_pkg::S_STOP_WAIT: begin
                if (wait_done) begin
                    state_d = ebs_pkg::S_ZERO;
                end
            end
            ebs_pkg::S_ZERO: begin
                if (out_freq_in == '0) begin
                    state_d = ebs_pkg::S_IDLE;
                end
            end
            ebs_pkg::S_TRIP: begin
                if (trip_clear) begin
                    state_d = ebs_pkg::S_IDLE;
                end
            end
            default: begin
                state_d = ebs_pkg::S_IDLE;
            end
        endcase
        // Dropping the enable mid-sequence returns to idle with the brake engaged.
        if (!ctrl_en_q && state_q != ebs_pkg::S_TRIP) begin
            state_d = ebs_pkg::S_IDLE;
            ev = '0;
        end
    end

    assign released_d = (state_d == ebs_pkg::S_CONF_ON) || (state_d == ebs_pkg::S_ACC_WAIT) ||
                        (state_d == ebs_pkg::S_RUN) || (state_d == ebs_pkg::S_DOWN);

    always_comb begin
        case (state_d)
            ebs_pkg::S_RUN: freq_d = cmd_freq_in;
            ebs_pkg::S_IDLE: freq_d = (bypass && run_cmd_in) ? cmd_freq_in : '0;
            ebs_pkg::S_ZERO: freq_d = '0;
            ebs_pkg::S_TRIP: freq_d = '0;
            default: freq_d = rel_freq_q;
        endcase
    end

    // A set arriving with its clear is kept.
    assign int_stat_d = (int_stat_q & ~(wr_int_clr ? hwdata_in[EW-1:0] : '0)) | ev;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ebs_pkg::S_IDLE;
            run_prev_q <= 1'b0;
            int_stat_q <= '0;
            irq_out <= 1'b0;
            brake_release_out <= 1'b0;
            brake_error_out <= 1'b0;
            trip_out <= 1'b0;
            motor_run_out <= 1'b0;
            freq_target_out <= '0;
        end else if (ce_in) begin
            state_q <= state_d;
            run_prev_q <= run_cmd_in;
            int_stat_q <= int_stat_d;
            irq_out <= |(int_stat_d & int_en_q);
            brake_release_out <= released_d;
            brake_error_out <= (state_d == ebs_pkg::S_TRIP);
            trip_out <= (state_d == ebs_pkg::S_TRIP);
            motor_run_out <= (state_d != ebs_pkg::S_IDLE && state_d != ebs_pkg::S_TRIP) ||
                             (state_d == ebs_pkg::S_IDLE && bypass && run_cmd_in);
            freq_target_out <= freq_d;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_en_q <= 1'b0;
            bok_assigned_q <= 1'b0;
            rel_wait_q <= '0;
            acc_wait_q <= '0;
            stop_wait_q <= '0;
            conf_wait_q <= '0;
            rel_freq_q <= '0;
            rel_cur_q <= ebs_pkg::RCUR_RST;
            int_en_q <= '0;
        end else if (ce_in && bus_wr) begin
            if (bus_addr == ebs_pkg::A_CTRL) begin
                ctrl_en_q <= hwdata_in[ebs_pkg::CTRL_EN_BIT];
                bok_assigned_q <= hwdata_in[ebs_pkg::CTRL_BOK_BIT];
            end else if (bus_addr == ebs_pkg::A_REL_WAIT) begin
                rel_wait_q <= WW'(sat(hwdata_in, 32'(ebs_pkg::WAIT_MAX)));
            end else if (bus_addr == ebs_pkg::A_ACC_WAIT) begin
                acc_wait_q <= WW'(sat(hwdata_in, 32'(ebs_pkg::WAIT_MAX)));
            end else if (bus_addr == ebs_pkg::A_STOP_WAIT) begin
                stop_wait_q <= WW'(sat(hwdata_in, 32'(ebs_pkg::WAIT_MAX)));
            end else if (bus_addr == ebs_pkg::A_CONF_WAIT) begin
                conf_wait_q <= WW'(sat(hwdata_in, 32'(ebs_pkg::WAIT_MAX)));
            end else if (bus_addr == ebs_pkg::A_REL_FREQ) begin
                rel_freq_q <= sat(hwdata_in, 32'(ebs_pkg::RFREQ_MAX));
            end else if (bus_addr == ebs_pkg::A_REL_CUR) begin
                rel_cur_q <= RW'(sat(hwdata_in, 32'(ebs_pkg::RCUR_MAX)));
            end else if (bus_addr == ebs_pkg::A_INT_EN) begin
                int_en_q <= hwdata_in[EW-1:0];
            end
        end
    end

    // Read mux; unmapped and write-only words read as zero.
    always_comb begin
        rdata = '0;
        if (bus_addr == ebs_pkg::A_CTRL) begin
            rdata[ebs_pkg::CTRL_EN_BIT] = ctrl_en_q;
            rdata[ebs_pkg::CTRL_BOK_BIT] = bok_assigned_q;
        end else if (bus_addr == ebs_pkg::A_REL_WAIT) begin
            rdata[WW-1:0] = rel_wait_q;
        end else if (bus_addr == ebs_pkg::A_ACC_WAIT) begin
            rdata[WW-1:0] = acc_wait_q;
        end else if (bus_addr == ebs_pkg::A_STOP_WAIT) begin
            rdata[WW-1:0] = stop_wait_q;
        end else if (bus_addr == ebs_pkg::A_CONF_WAIT) begin
            rdata[WW-1:0] = conf_wait_q;
        end else if (bus_addr == ebs_pkg::A_REL_FREQ) begin
            rdata[FREQ_W-1:0] = rel_freq_q;
        end else if (bus_addr == ebs_pkg::A_REL_CUR) begin
            rdata[RW-1:0] = rel_cur_q;
        end else if (bus_addr == ebs_pkg::A_STATUS) begin
            rdata[ebs_pkg::ST_W-1:0] = state_q;
            rdata[ebs_pkg::STAT_BOK_BIT] = brake_confirm_in;
            rdata[ebs_pkg::STAT_ERR_BIT] = brake_error_out;
        end else if (bus_addr == ebs_pkg::A_INT_STAT) begin
            rdata[EW-1:0] = int_stat_q;
        end else if (bus_addr == ebs_pkg::A_INT_EN) begin
            rdata[EW-1:0] = int_en_q;
        end
    end
endmodule

// ==== verification/ebs_brake_model.sv ====
`timescale 1ns/100ps
module ebs_brake_model #(
    parameter int unsigned DELAY = 4
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic brake_release_in,
    input wire logic [1:0] mode_in,
    output logic brake_confirm_out
);
    // Mode 0 follows the brake, 1 keeps the contact open, 2 sticks it closed once made.
    // DELAY stays well below the confirm wait so a healthy brake never times out.
    logic [DELAY-1:0] travel_q;
    logic confirm_q;

    assign brake_confirm_out = confirm_q;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            travel_q <= '0;
            confirm_q <= 1'h0;
        end else begin
            travel_q <= {travel_q[DELAY-2:0], brake_release_in};
            case (mode_in)
                2'h1: confirm_q <= 1'h0;
                2'h2: confirm_q <= confirm_q | travel_q[DELAY-1];
                default: confirm_q <= travel_q[DELAY-1];
            endcase
        end
    end
endmodule

// ==== verification/ebs_sequencer_sva.sv ====
`timescale 1ns/100ps
module ebs_sequencer_sva #(
    parameter int unsigned FREQ_W = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic run_cmd_in,
    input wire logic [FREQ_W-1:0] out_freq_in,
    input wire logic brake_confirm_in,
    input wire logic hwrite_in,
    input wire logic brake_release_out,
    input wire logic brake_error_out,
    input wire logic trip_out,
    input wire logic motor_run_out,
    input wire logic [FREQ_W-1:0] freq_target_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    err_trip_same_a: assert property (brake_error_out == trip_out)
        else $error("brake error and trip differ");
    err_safe_out_a: assert property (brake_error_out |-> !brake_release_out && !motor_run_out)
        else $error("output active during trip");
    err_held_a: assert property ($fell(brake_error_out) |-> $past(hwrite_in) || $past(hwrite_in, 2))
        else $error("trip left without a write");
    rel_at_freq_a: assert property ($rose(brake_release_out) |-> out_freq_in >= freq_target_out && motor_run_out)
        else $error("release before release frequency");
    rel_hold_a: assert property ($rose(brake_release_out) |=> $stable(freq_target_out))
        else $error("acceleration right at release");
    drop_at_rel_a: assert property ($fell(brake_release_out) && !brake_error_out |-> !run_cmd_in && out_freq_in <= freq_target_out)
        else $error("release dropped above release frequency");
    stop_hold_a: assert property ($fell(brake_release_out) && !brake_error_out |=> $stable(freq_target_out))
        else $error("deceleration right at drop");
    lost_trip_a: assert property (brake_release_out && !run_cmd_in && $fell(brake_confirm_in) |-> ##[1:3] brake_error_out)
        else $error("confirm lost without trip");
    idle_no_rel_a: assert property (!motor_run_out |-> !brake_release_out)
        else $error("release without motor output");

    release_seen_c: cover property ($rose(brake_release_out));
    error_seen_c: cover property ($rose(brake_error_out));
    lost_seen_c: cover property (brake_release_out && $fell(brake_confirm_in));
endmodule

bind ebs_sequencer ebs_sequencer_sva #(.FREQ_W(FREQ_W)) u_ebs_sequencer_sva (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .run_cmd_in(run_cmd_in),
    .out_freq_in(out_freq_in), .brake_confirm_in(brake_confirm_in), .hwrite_in(hwrite_in),
    .brake_release_out(brake_release_out), .brake_error_out(brake_error_out),
    .trip_out(trip_out), .motor_run_out(motor_run_out), .freq_target_out(freq_target_out)
);

// ==== verification/ebs_sequencer_bench.sv ====
`timescale 1ns/100ps
module ebs_sequencer_bench;
    localparam int TK = 4;
    localparam logic [15:0] REL_F = 16'h0064;
    localparam logic [15:0] CMD_F = 16'h0190;
    logic clk_in, sys_rst_in, run_cmd_in, hsel_in, hwrite_in, brake_confirm_in, ce_in;
    logic hreadyout_out, hresp_out, brake_release_out, brake_error_out, trip_out;
    logic motor_run_out, irq_out;
    logic [15:0] cmd_freq_in, out_freq_in, freq_target_out;
    logic [7:0] out_current_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
    logic [1:0] htrans_in, brk_mode;
    int miscompares, checked;

    ebs_sequencer #(.TICK_CYCLES(TK)) u_ebs_sequencer (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .run_cmd_in(run_cmd_in),
        .cmd_freq_in(cmd_freq_in), .out_freq_in(out_freq_in), .out_current_in(out_current_in),
        .brake_confirm_in(brake_confirm_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
        .hready_in(hreadyout_out), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .brake_release_out(brake_release_out), .brake_error_out(brake_error_out),
        .trip_out(trip_out), .motor_run_out(motor_run_out),
        .freq_target_out(freq_target_out), .irq_out(irq_out)
    );
    ebs_brake_model u_ebs_brake_model (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .brake_release_in(brake_release_out),
        .mode_in(brk_mode), .brake_confirm_out(brake_confirm_in)
    );

    initial begin
        clk_in = 1'h0;
        forever #50 clk_in = ~clk_in;
    end

    // The drive ramp reaches any target one cycle after it is set.
    always @(posedge clk_in) begin
        out_freq_in <= freq_target_out;
    end

    task automatic report_and_stop();
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (n > 20) begin
                miscompares++;
                report_and_stop();
            end
        end while (hreadyout_out !== 1'h1);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel_in <= 1'h1;
        htrans_in <= 2'h2;
        haddr_in <= {24'h0, a};
        hwrite_in <= wr;
        wait_ready();
        hsel_in <= 1'h0;
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        wait_ready();
        rd = hrdata_out;
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return brake_release_out;
            1: return brake_error_out;
            2: return freq_target_out === CMD_F;
            default: return motor_run_out;
        endcase
    endfunction

    task automatic wait_on(input int sel, input logic v, output int n);
        n = 0;
        while (pick(sel) !== v) begin
            @(posedge clk_in);
            n++;
            if (n > 3000) begin
                miscompares++;
                report_and_stop();
            end
        end
    endtask

    task automatic t_regs();
        bus(1'h0, ebs_pkg::A_REL_CUR, 32'h0);
        check("release current reset", rd, 32'h0000_000a);
        bus(1'h0, ebs_pkg::A_STATUS, 32'h0);
        check("status after reset", rd, 32'h1);
        bus(1'h1, ebs_pkg::A_STOP_WAIT, 32'h0000_0258);
        bus(1'h0, ebs_pkg::A_STOP_WAIT, 32'h0);
        check("stop wait ceiling", rd, 32'h0000_01f4);
        bus(1'h0, 8'h3c, 32'h0);
        check("unmapped read", rd, 32'h0);
        check("hresp okay", 32'(hresp_out), 32'h0);
        for (int i = 1; i < 5; i++) begin
            bus(1'h1, 8'(4 * i), 32'h2);
        end
        bus(1'h1, ebs_pkg::A_REL_FREQ, {16'h0, REL_F});
        bus(1'h0, ebs_pkg::A_REL_FREQ, 32'h0);
        check("release frequency", rd, {16'h0, REL_F});
    endtask

    task automatic t_cycle(input logic assigned);
        int n;
        brk_mode <= assigned ? 2'h0 : 2'h1;
        bus(1'h1, ebs_pkg::A_CTRL, {30'h0, assigned, 1'h1});
        run_cmd_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        check("target at start", 32'(freq_target_out), 32'(REL_F));
        wait_on(0, 1'h1, n);
        check("target at release", 32'(freq_target_out), 32'(REL_F));
        check("release wait", 32'(n >= TK), 32'h1);
        wait_on(2, 1'h1, n);
        check("confirm before accel", 32'(brake_confirm_in), 32'(assigned));
        check("accel wait", 32'(n >= 2 * TK), 32'h1);
        run_cmd_in <= 1'h0;
        wait_on(0, 1'h0, n);
        check("target at drop", 32'(freq_target_out), 32'(REL_F));
        wait_on(3, 1'h0, n);
        check("stop wait", 32'(n >= 2 * TK), 32'h1);
        check("no error", 32'(brake_error_out), 32'h0);
    endtask

    // Fault 0 low current, 1 brake never opens, 2 brake never closes, 3 contact lost.
    task automatic t_fault(input int k);
        int n;
        bus(1'h1, ebs_pkg::A_INT_EN, (k == 0) ? 32'h0 : 32'hf);
        out_current_in <= (k == 0) ? 8'h09 : 8'h14;
        brk_mode <= (k == 3) ? 2'h0 : 2'(k);
        bus(1'h1, ebs_pkg::A_CTRL, 32'h3);
        run_cmd_in <= 1'h1;
        if (k >= 2) begin
            wait_on(2, 1'h1, n);
            run_cmd_in <= 1'h0;
            if (k == 3) begin
                brk_mode <= 2'h1;
            end
        end
        wait_on(1, 1'h1, n);
        check("release in trip", 32'(brake_release_out), 32'h0);
        bus(1'h0, ebs_pkg::A_INT_STAT, 32'h0);
        check("event bit", rd, 32'h1 << k);
        check("irq level", 32'(irq_out), 32'(k != 0));
        bus(1'h1, ebs_pkg::A_INT_CLR, 32'hf);
        bus(1'h0, ebs_pkg::A_INT_STAT, 32'h0);
        check("event cleared", rd, 32'h0);
        check("irq cleared", 32'(irq_out), 32'h0);
        run_cmd_in <= 1'h0;
        brk_mode <= 2'h0;
        check("error latched", 32'(brake_error_out), 32'h1);
        bus(1'h1, ebs_pkg::A_CTRL, 32'h7);
        bus(1'h0, ebs_pkg::A_STATUS, 32'h0);
        check("trip reset", rd, 32'h1);
        out_current_in <= 8'h14;
    endtask

    task automatic t_disable();
        bus(1'h1, ebs_pkg::A_CTRL, 32'h0);
        run_cmd_in <= 1'h1;
        repeat (6 * TK) begin
            @(posedge clk_in);
            check("release disabled", 32'(brake_release_out), 32'h0);
        end
        check("bypass run", 32'(motor_run_out), 32'h1);
        check("bypass freq", 32'(freq_target_out), 32'(CMD_F));
        ce_in <= 1'h0;
        run_cmd_in <= 1'h0;
        repeat (3) @(posedge clk_in);
        check("frozen run", 32'(motor_run_out), 32'h1);
        ce_in <= 1'h1;
        run_cmd_in <= 1'h0;
    endtask

    initial begin
        miscompares = 0;
        checked = 0;
        sys_rst_in = 1'h1;
        ce_in = 1'h1;
        run_cmd_in = 1'h0;
        cmd_freq_in = CMD_F;
        out_freq_in = 16'h0;
        out_current_in = 8'h14;
        hsel_in = 1'h0;
        haddr_in = 32'h0;
        htrans_in = 2'h0;
        hwrite_in = 1'h0;
        hwdata_in = 32'h0;
        brk_mode = 2'h0;
        rd = 32'h0;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        @(posedge clk_in);
        t_regs();
        t_cycle(1'h1);
        t_cycle(1'h0);
        for (int k = 0; k < 4; k++) begin
            t_fault(k);
        end
        t_disable();
        report_and_stop();
    end
endmodule
